// file: rtl/synth_defs.svh
// register map, field positions and timing figures of the synthesizer control
`ifndef SYNTH_DEFS_SVH
`define SYNTH_DEFS_SVH

// register addresses (serial frame address field)
`define ADDR_REF_DIV 6'h02
`define ADDR_FB_INT 6'h03
`define ADDR_FB_FRAC 6'h04
`define ADDR_MOD_CFG 6'h06
`define ADDR_LD_CFG 6'h07
`define ADDR_CP_CFG 6'h09
`define ADDR_CAL_CFG 6'h0A
`define ADDR_EXACT_CFG 6'h0C
`define ADDR_LD_PIN_SEL 6'h0F
`define ADDR_MAN_SUBBAND 6'h15
`define ADDR_OUT_DIV_GAIN 6'h16
`define ADDR_OUT_STAGE 6'h17

// reset value of every register
`define REG_RESET 24'h000000

// calibration_config fields
`define CAL_MEAS_MSB 2
`define CAL_MEAS_LSB 0
`define CAL_DISABLE_BIT 11
`define CAL_FSMDIV_MSB 14
`define CAL_FSMDIV_LSB 13
`define CAL_RELOCK_BIT 17
// modulator_config: fractional mode enable
`define MOD_FRAC_MODE_BIT 11
// manual_subband field
`define SUBBAND_MSB 8
`define SUBBAND_LSB 1
// output_divider_gain fields
`define OUTDIV_MSB 5
`define OUTDIV_LSB 0
`define GAIN_A_MSB 7
`define GAIN_A_LSB 6
`define GAIN_B_MSB 9
`define GAIN_B_LSB 8
// output_stage_config fields
`define OUT_MODE_MSB 9
`define OUT_MODE_LSB 8
`define MUTE_UNLOCK_BIT 7
// lock_pin_select field
`define LD_SEL_MSB 1
`define LD_SEL_LSB 0

// output divider codes
`define OUTDIV_MUTE 6'h00
`define OUTDIV_FUND 6'h01
// fractional word width
`define FRAC_BITS 24

// serial frame: rw, 6 address bits, pad, 24 data bits
`define FRAME_LAST 6'd31
`define FRAME_HDR_LAST 6'd7
`define FRAME_DONE 6'd32

// calibration state machine clock ceiling
`define FSM_CLK_MAX_HZ 50000000

`endif

// file: rtl/synth_pkg.sv
// types shared by the synthesizer control modules
package synth_pkg;
  typedef logic [23:0] reg_word_t;
  typedef enum logic [1:0] {LDPIN_LOW, LDPIN_LOCK, LDPIN_MIXED, LDPIN_READBACK} ld_pin_t;
  typedef enum {CAL_IDLE, CAL_TRIAL, CAL_MEASURE, CAL_DECIDE, CAL_APPLY} cal_state_t;
endpackage : synth_pkg

// file: rtl/reg_bus_if.sv
// register access carrier between serial port and control core
`timescale 1ns/1ns
interface reg_bus_if;
  logic wr_stb;
  logic [5:0] addr;
  logic [23:0] wr_data;
  logic [23:0] rd_data;
  logic rd_active;
  modport port (output wr_stb, output addr, output wr_data, output rd_active, input rd_data);
  modport core (input wr_stb, input addr, input wr_data, input rd_active, output rd_data);
endinterface : reg_bus_if

// file: rtl/main_serial_port.sv
// main serial port: 32-bit frames in, 24-bit readback out
`timescale 1ns/1ns
module main_serial_port
  import synth_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_ser_enable,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  output logic o_ser_readback,
  reg_bus_if.port bus
);
`include "synth_defs.svh"

  logic sck_prev_ff, nxt_sck_prev;
  logic [31:0] shift_ff, nxt_shift;
  logic [5:0] count_ff, nxt_count;
  logic [23:0] rd_shift_ff, nxt_rd_shift;
  logic rd_act_ff, nxt_rd_act;
  logic rise;

  // rising serial clock inside an active frame
  assign rise = i_ser_enable && i_ser_clk && !sck_prev_ff && (count_ff != `FRAME_DONE);
  // address comes from the header, or from the full frame on its last bit
  assign bus.addr = (count_ff == `FRAME_LAST) ? shift_ff[29:24] : shift_ff[5:0];
  assign bus.wr_data = {shift_ff[22:0], i_ser_data};
  assign bus.wr_stb = rise && (count_ff == `FRAME_LAST) && !shift_ff[30];
  assign bus.rd_active = rd_act_ff;
  assign o_ser_readback = rd_shift_ff[23];

  // frame shifter, bit counter and readback shifter
  always_comb begin
    nxt_sck_prev = i_ser_clk;
    nxt_shift = shift_ff;
    nxt_count = count_ff;
    nxt_rd_shift = rd_shift_ff;
    nxt_rd_act = rd_act_ff;
    if (!i_ser_enable) begin
      nxt_count = 6'h00;
      nxt_rd_act = 1'b0;
    end else if (rise) begin
      nxt_shift = {shift_ff[30:0], i_ser_data};
      nxt_count = count_ff + 6'h01;
      if (count_ff == `FRAME_HDR_LAST && shift_ff[6]) begin
        nxt_rd_shift = bus.rd_data; // read header complete
        nxt_rd_act = 1'b1;
      end else if (rd_act_ff) begin
        nxt_rd_shift = {rd_shift_ff[22:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sck_prev_ff <= 1'b0;
      shift_ff <= 32'h00000000;
      count_ff <= 6'h00;
      rd_shift_ff <= 24'h000000;
      rd_act_ff <= 1'b0;
    end else begin
      sck_prev_ff <= nxt_sck_prev;
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
      rd_shift_ff <= nxt_rd_shift;
      rd_act_ff <= nxt_rd_act;
    end
  end
endmodule : main_serial_port

// file: rtl/synth_vco_subband_self_calibration_control.sv
// synthesizer digital control: register file, sub-band self calibration, output stage
//
// Behaviour
// - calibration enabled picks sub-band itself
// - each frequency change starts one calibration
// - rewriting same frequency recalibrates, same result
// - clamp tuning voltage, measure, nearest sub-band
// - auto-relock reruns calibration once on unlock
// - manual sub-band register drives switches directly
// - integer, fraction, reference divider from registers
// - output divider one or even two..62
// - two gain fields, one per output
// - two-bit field selects single or differential
// - mute outputs while unlocked if enabled
// - divider field zero mutes outputs permanently
// - lock detect config and pin select registers
// - chip enable pin gates operation
// - modulator and exact-frequency configuration registers
// - charge pump settings from own register
// - state machine clock is reference over 2^m
// - measurement lasts phase-detector period times 2^n
// - fraction loads after calibration, else immediately
// - chosen sub-band readable in manual register
`timescale 1ns/1ns
module synth_vco_subband_self_calibration_control
  import synth_pkg::*;
#(
  parameter int REF_CLOCK_HZ = 20000000,
  parameter int SUBBAND_W = 8
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_chip_enable_pin,
  input wire logic i_ser_enable,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_lock_indicator,
  input wire logic i_vco_pulse,
  output logic o_lock_or_readback_pin,
  output logic o_core_enable,
  output logic o_vtune_clamp,
  output logic o_cal_busy,
  output logic [SUBBAND_W-1:0] o_vco_subband,
  output logic [23:0] o_ref_div,
  output logic [23:0] o_n_int,
  output logic [23:0] o_n_frac,
  output logic [23:0] o_modulator_cfg,
  output logic [23:0] o_exact_cfg,
  output logic [23:0] o_lock_detect_cfg,
  output logic [23:0] o_charge_pump_cfg,
  output logic [5:0] o_out_div_ratio,
  output logic [1:0] o_gain_a,
  output logic [1:0] o_gain_b,
  output logic [1:0] o_out_mode,
  output logic o_rf_mute
);
`include "synth_defs.svh"

  // elaboration checks
  if (SUBBAND_W != (`SUBBAND_MSB - `SUBBAND_LSB + 1)) begin : g_bad_width
    $error("sub-band width must match the manual tuning field");
  end
  if (REF_CLOCK_HZ > `FSM_CLK_MAX_HZ) begin : g_bad_clock
    $error("reference too fast for an undivided state machine clock");
  end

  // mapped register addresses
  function automatic logic is_mapped(input logic [5:0] a);
    case (a)
      `ADDR_REF_DIV, `ADDR_FB_INT, `ADDR_FB_FRAC, `ADDR_MOD_CFG, `ADDR_LD_CFG,
      `ADDR_CP_CFG, `ADDR_CAL_CFG, `ADDR_EXACT_CFG, `ADDR_LD_PIN_SEL,
      `ADDR_MAN_SUBBAND, `ADDR_OUT_DIV_GAIN, `ADDR_OUT_STAGE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // control value to measurement exponent n (4..7 skip n=4)
  function automatic logic [3:0] meas_exp(input logic [2:0] c);
    meas_exp = (c > 3'h3) ? ({1'b0, c} + 4'h1) : {1'b0, c};
  endfunction : meas_exp

  // two-bit field to state machine divider exponent m
  function automatic logic [2:0] fsm_exp(input logic [1:0] f);
    case (f)
      2'h0: fsm_exp = 3'h0;
      2'h1: fsm_exp = 3'h2;
      2'h2: fsm_exp = 3'h4;
      default: fsm_exp = 3'h5;
    endcase
  endfunction : fsm_exp

  // expected vco count floor(N * 2^n)
  function automatic logic [31:0] target_count(input logic [23:0] ni, input logic [23:0] nf,
                                                input logic [3:0] n);
    logic [55:0] full;
    full = {8'h00, ni, nf} << n;
    target_count = full[55:24];
  endfunction : target_count

  logic ser_readback;
  reg_bus_if bus ();
  main_serial_port u_port (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_ser_enable(i_ser_enable),
    .i_ser_clk(i_ser_clk),
    .i_ser_data(i_ser_data),
    .o_ser_readback(ser_readback),
    .bus(bus.port)
  );
  reg_word_t regs_ff [0:63];
  reg_word_t nxt_regs [0:63];
  logic [23:0] int_app_ff, nxt_int_app, frac_app_ff, nxt_frac_app;
  logic [SUBBAND_W-1:0] sub_app_ff, nxt_sub_app;
  cal_state_t state_ff, nxt_state;
  logic [4:0] tick_cnt_ff, nxt_tick_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [SUBBAND_W-1:0] sar_ff, nxt_sar, trial_ff, nxt_trial, best_ff, nxt_best;
  logic [31:0] best_err_ff, nxt_best_err, win_ff, nxt_win, vco_cnt_ff, nxt_vco_cnt;
  logic [31:0] target_ff, nxt_target;
  logic relock_used_ff, nxt_relock_used, lock_prev_ff, nxt_lock_prev;
  logic mute_ff, nxt_mute, ld_pin_ff, nxt_ld_pin;
  logic [5:0] div_ff, nxt_div;

  logic [23:0] cal_cfg, mod_cfg;
  logic cal_enabled, freq_req, relock_req, tick, cal_done;
  logic [3:0] n_exp;
  logic [4:0] tick_mask;
  logic [31:0] err;
  ld_pin_t ld_sel;

  assign cal_cfg = regs_ff[`ADDR_CAL_CFG];
  assign mod_cfg = regs_ff[`ADDR_MOD_CFG];
  assign cal_enabled = !cal_cfg[`CAL_DISABLE_BIT];
  assign n_exp = meas_exp(cal_cfg[`CAL_MEAS_MSB:`CAL_MEAS_LSB]);
  assign tick_mask = 5'((6'h01 << fsm_exp(cal_cfg[`CAL_FSMDIV_MSB:`CAL_FSMDIV_LSB])) - 6'h01);
  assign tick = ((tick_cnt_ff & tick_mask) == tick_mask);
  // fraction write, or integer write in integer mode, is a frequency change
  assign freq_req = bus.wr_stb && cal_enabled && i_chip_enable_pin
    && ((bus.addr == `ADDR_FB_FRAC)
    || (bus.addr == `ADDR_FB_INT && !mod_cfg[`MOD_FRAC_MODE_BIT]));
  assign relock_req = cal_enabled && i_chip_enable_pin && cal_cfg[`CAL_RELOCK_BIT]
    && lock_prev_ff && !i_lock_indicator && !relock_used_ff
    && (state_ff == CAL_IDLE);
  assign cal_done = (state_ff == CAL_APPLY) && tick;
  assign err = (vco_cnt_ff > target_ff) ? (vco_cnt_ff - target_ff) : (target_ff - vco_cnt_ff);
  assign bus.rd_data = is_mapped(bus.addr) ? regs_ff[bus.addr] : 24'h000000;
  assign ld_sel = ld_pin_t'(regs_ff[`ADDR_LD_PIN_SEL][`LD_SEL_MSB:`LD_SEL_LSB]);

  // register file with immediate loads when calibration is off
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    nxt_int_app = int_app_ff;
    nxt_frac_app = frac_app_ff;
    nxt_sub_app = sub_app_ff;
    if (bus.wr_stb && is_mapped(bus.addr)) begin
      nxt_regs[bus.addr] = bus.wr_data;
      if (!cal_enabled && bus.addr == `ADDR_FB_INT) begin
        nxt_int_app = bus.wr_data;
      end
      if (!cal_enabled && bus.addr == `ADDR_FB_FRAC) begin
        nxt_frac_app = bus.wr_data;
      end
      if (!cal_enabled && bus.addr == `ADDR_MAN_SUBBAND) begin
        nxt_sub_app = bus.wr_data[`SUBBAND_MSB:`SUBBAND_LSB];
      end
    end
    if (cal_done) begin
      // new dividers and sub-band take effect together
      nxt_int_app = regs_ff[`ADDR_FB_INT];
      nxt_frac_app = regs_ff[`ADDR_FB_FRAC];
      nxt_sub_app = best_ff;
      nxt_regs[`ADDR_MAN_SUBBAND][`SUBBAND_MSB:`SUBBAND_LSB] = best_ff;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 64; i++) begin
        regs_ff[i] <= `REG_RESET;
      end
      int_app_ff <= 24'h000000;
      frac_app_ff <= 24'h000000;
      sub_app_ff <= '0;
    end else begin
      regs_ff <= nxt_regs;
      int_app_ff <= nxt_int_app;
      frac_app_ff <= nxt_frac_app;
      sub_app_ff <= nxt_sub_app;
    end
  end

  // calibration state machine: successive approximation over sub-bands
  always_comb begin
    nxt_state = state_ff;
    nxt_tick_cnt = tick_cnt_ff + 5'h01;
    nxt_bit = bit_ff;
    nxt_sar = sar_ff;
    nxt_trial = trial_ff;
    nxt_best = best_ff;
    nxt_best_err = best_err_ff;
    nxt_win = win_ff;
    nxt_vco_cnt = vco_cnt_ff;
    nxt_target = target_ff;
    nxt_relock_used = relock_used_ff;
    nxt_lock_prev = i_lock_indicator;
    case (state_ff)
      CAL_IDLE: ;
      CAL_TRIAL: if (tick) begin
        nxt_vco_cnt = 32'h00000000;
        // window is the phase-detector period times 2^n
        nxt_win = ((regs_ff[`ADDR_REF_DIV] == 24'h000000) ? 32'h00000001
          : {8'h00, regs_ff[`ADDR_REF_DIV]}) << n_exp;
        nxt_state = CAL_MEASURE;
      end
      CAL_MEASURE: begin
        nxt_vco_cnt = vco_cnt_ff + {31'h00000000, i_vco_pulse};
        nxt_win = win_ff - 32'h00000001;
        if (win_ff == 32'h00000001) begin
          nxt_state = CAL_DECIDE;
        end
      end
      CAL_DECIDE: if (tick) begin
        // higher code adds capacitance and lowers the frequency
        if (vco_cnt_ff > target_ff) begin
          nxt_sar = trial_ff;
        end
        if (err < best_err_ff) begin
          nxt_best = trial_ff;
          nxt_best_err = err;
        end
        if (bit_ff == 4'h0) begin
          nxt_state = CAL_APPLY;
        end else begin
          nxt_bit = bit_ff - 4'h1;
          nxt_trial = nxt_sar | SUBBAND_W'(1 << (bit_ff - 4'h1)); // settles before count
          nxt_state = CAL_TRIAL;
        end
      end
      CAL_APPLY: if (tick) begin
        nxt_state = CAL_IDLE;
      end
      default: nxt_state = CAL_IDLE;
    endcase
    if (freq_req || relock_req) begin
      // a new request restarts any run in progress
      nxt_state = CAL_TRIAL;
      nxt_bit = 4'(SUBBAND_W - 1);
      nxt_sar = '0;
      nxt_trial = SUBBAND_W'(1 << (SUBBAND_W - 1));
      nxt_best = sub_app_ff;
      nxt_best_err = 32'hFFFFFFFF;
      nxt_target = target_count(freq_req && bus.addr == `ADDR_FB_INT ? bus.wr_data
        : regs_ff[`ADDR_FB_INT], freq_req && bus.addr == `ADDR_FB_FRAC ? bus.wr_data
        : regs_ff[`ADDR_FB_FRAC], n_exp);
      nxt_relock_used = relock_req ? 1'b1 : 1'b0;
    end
    if (!i_chip_enable_pin || !cal_enabled) begin
      nxt_state = CAL_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff <= CAL_IDLE;
      tick_cnt_ff <= 5'h00;
      bit_ff <= 4'h0;
      sar_ff <= '0;
      trial_ff <= '0;
      best_ff <= '0;
      best_err_ff <= 32'hFFFFFFFF;
      win_ff <= 32'h00000000;
      vco_cnt_ff <= 32'h00000000;
      target_ff <= 32'h00000000;
      relock_used_ff <= 1'b0;
      lock_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tick_cnt_ff <= nxt_tick_cnt;
      bit_ff <= nxt_bit;
      sar_ff <= nxt_sar;
      trial_ff <= nxt_trial;
      best_ff <= nxt_best;
      best_err_ff <= nxt_best_err;
      win_ff <= nxt_win;
      vco_cnt_ff <= nxt_vco_cnt;
      target_ff <= nxt_target;
      relock_used_ff <= nxt_relock_used;
      lock_prev_ff <= nxt_lock_prev;
    end
  end

  // output stage: divider decode, mute and lock pin selection
  always_comb begin
    logic [5:0] code;
    code = regs_ff[`ADDR_OUT_DIV_GAIN][`OUTDIV_MSB:`OUTDIV_LSB];
    if (code == `OUTDIV_MUTE || code == `OUTDIV_FUND) begin
      nxt_div = code;
    end else begin
      nxt_div = {code[5:1], 1'b0}; // odd ratios round down to even
    end
    nxt_mute = !i_chip_enable_pin || (code == `OUTDIV_MUTE)
      || (regs_ff[`ADDR_OUT_STAGE][`MUTE_UNLOCK_BIT] && !i_lock_indicator);
    case (ld_sel)
      LDPIN_LOW: nxt_ld_pin = 1'b0;
      LDPIN_LOCK: nxt_ld_pin = i_lock_indicator;
      LDPIN_MIXED: nxt_ld_pin = bus.rd_active ? ser_readback : i_lock_indicator;
      default: nxt_ld_pin = ser_readback;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      div_ff <= `OUTDIV_MUTE;
      mute_ff <= 1'b1;
      ld_pin_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      mute_ff <= nxt_mute;
      ld_pin_ff <= nxt_ld_pin;
    end
  end

  // outputs from flops, except core enable, which follows the pin directly
  assign o_core_enable = i_chip_enable_pin;
  assign o_cal_busy = (state_ff != CAL_IDLE);
  assign o_vtune_clamp = (state_ff != CAL_IDLE);
  assign o_vco_subband = (state_ff == CAL_IDLE) ? sub_app_ff : trial_ff;
  assign o_ref_div = regs_ff[`ADDR_REF_DIV];
  assign o_n_int = int_app_ff;
  assign o_n_frac = frac_app_ff;
  assign o_modulator_cfg = regs_ff[`ADDR_MOD_CFG];
  assign o_exact_cfg = regs_ff[`ADDR_EXACT_CFG];
  assign o_lock_detect_cfg = regs_ff[`ADDR_LD_CFG];
  assign o_charge_pump_cfg = regs_ff[`ADDR_CP_CFG];
  assign o_out_div_ratio = div_ff;
  assign o_gain_a = regs_ff[`ADDR_OUT_DIV_GAIN][`GAIN_A_MSB:`GAIN_A_LSB];
  assign o_gain_b = regs_ff[`ADDR_OUT_DIV_GAIN][`GAIN_B_MSB:`GAIN_B_LSB];
  assign o_out_mode = regs_ff[`ADDR_OUT_STAGE][`OUT_MODE_MSB:`OUT_MODE_LSB];
  assign o_rf_mute = mute_ff;
  assign o_lock_or_readback_pin = ld_pin_ff;
endmodule : synth_vco_subband_self_calibration_control

// file: bench/synth_ctl_asserts.sv
// port-level assertions for the synthesizer control block
`timescale 1ns/1ns
module synth_ctl_asserts (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_chip_enable_pin,
  input wire logic i_ser_enable,
  input wire logic i_lock_indicator,
  input wire logic o_core_enable,
  input wire logic o_vtune_clamp,
  input wire logic o_cal_busy,
  input wire logic [23:0] o_ref_div,
  input wire logic [23:0] o_n_int,
  input wire logic [23:0] o_n_frac,
  input wire logic [23:0] o_modulator_cfg,
  input wire logic [23:0] o_exact_cfg,
  input wire logic [23:0] o_lock_detect_cfg,
  input wire logic [23:0] o_charge_pump_cfg,
  input wire logic [5:0] o_out_div_ratio,
  input wire logic [1:0] o_gain_a,
  input wire logic [1:0] o_gain_b,
  input wire logic [1:0] o_out_mode,
  input wire logic o_rf_mute
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  // calibration running on two edges in a row
  sequence s_busy_two;
    o_cal_busy ##1 o_cal_busy;
  endsequence
  // serial port idle on two edges in a row
  sequence s_idle_two;
    !i_ser_enable ##1 !i_ser_enable;
  endsequence
  a_core_enable_follows: assert property (o_core_enable == i_chip_enable_pin)
    else $error("core enable differs from pin");
  a_clamp_while_busy: assert property (o_vtune_clamp == o_cal_busy)
    else $error("tuning clamp differs from busy");
  a_mute_when_off: assert property (!i_chip_enable_pin |=> o_rf_mute)
    else $error("outputs not muted while disabled");
  a_idle_when_off: assert property (!i_chip_enable_pin |=> !o_cal_busy)
    else $error("calibration runs while disabled");
  a_mute_div_zero: assert property (o_out_div_ratio == 6'h00 |-> ##[0:1] o_rf_mute)
    else $error("divider mute code not muting");
  a_div_held_busy: assert property (
    s_busy_two |-> $stable(o_n_int) && $stable(o_n_frac))
    else $error("dividers moved during calibration");
  a_regs_quiet: assert property (
    s_idle_two |-> $stable({o_ref_div, o_modulator_cfg, o_exact_cfg, o_lock_detect_cfg,
      o_charge_pump_cfg, o_gain_a, o_gain_b, o_out_mode}))
    else $error("settings changed with no serial frame");
  a_start_has_cause: assert property (
    $rose(o_cal_busy) |-> $past(i_ser_enable) || !$past(i_lock_indicator)
      || !$past(i_lock_indicator, 2) || !$past(i_lock_indicator, 3))
    else $error("calibration started without cause");
endmodule : synth_ctl_asserts

// file: bench/host_serial_model.sv
// host model: drives 32-bit serial frames and gathers readback bits
`timescale 1ns/1ns
module host_serial_model (
  input wire logic i_clock,
  input wire logic i_readback,
  output logic o_ser_enable,
  output logic o_ser_clk,
  output logic o_ser_data
);
  initial begin
    o_ser_enable = 1'b0;
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
  end
  // one frame msb first; clock held low and high for at least two cycles each
  task automatic frame(input logic rw, input logic [5:0] addr, input logic [23:0] data,
                       output logic [23:0] rd);
    logic [31:0] word;
    word = {rw, addr, 1'b0, data};
    rd = 24'h000000;
    @(posedge i_clock);
    o_ser_enable <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge i_clock);
      o_ser_clk <= 1'b0;
      o_ser_data <= word[i];
      @(posedge i_clock);
      @(negedge i_clock);
      if (i < 24) begin
        rd[i] = i_readback;
      end
      @(posedge i_clock);
      o_ser_clk <= 1'b1;
      repeat (2) @(posedge i_clock);
    end
    // released data line shows the inverse of its last bit
    @(posedge i_clock);
    o_ser_enable <= 1'b0;
    o_ser_clk <= 1'b0;
    o_ser_data <= ~o_ser_data;
    repeat (2) @(posedge i_clock);
  endtask : frame
endmodule : host_serial_model

// file: bench/synth_vco_subband_self_calibration_control_bench.sv
// self-checking bench for the synthesizer control block
`timescale 1ns/1ns
`include "synth_defs.svh"
module synth_vco_subband_self_calibration_control_bench
  import synth_pkg::*;
;
  logic clock;
  logic sys_rst;
  logic chip_en;
  logic lock;
  logic vco_pulse;
  logic ser_enable, ser_clk, ser_data, pin;
  logic core_en, clamp, busy, rf_mute;
  logic [7:0] subband;
  reg_word_t ref_div, n_int, n_frac, mod_cfg, exact_cfg, ld_cfg, cp_cfg;
  logic [5:0] div_ratio;
  logic [1:0] gain_a, gain_b, out_mode;
  logic [7:0] vco_cnt = 8'h00;
  logic [7:0] chosen;
  logic seen;
  reg_word_t rd_val;
  int mismatches = 0;
  int tests_run = 0;
  logic [5:0] cfg_addr [5] = '{`ADDR_REF_DIV, `ADDR_MOD_CFG, `ADDR_LD_CFG, `ADDR_CP_CFG,
    `ADDR_EXACT_CFG};
  reg_word_t cfg_val [5] = '{24'h000002, 24'h000A55, 24'h3C5A96, 24'hC3A5F0, 24'h5A5A5A};
  logic [5:0] div_in [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3E};
  logic [5:0] div_exp [5] = '{6'h00, 6'h01, 6'h02, 6'h02, 6'h3E};

  synth_vco_subband_self_calibration_control dut (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_chip_enable_pin(chip_en),
    .i_ser_enable(ser_enable), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
    .i_lock_indicator(lock), .i_vco_pulse(vco_pulse), .o_lock_or_readback_pin(pin),
    .o_core_enable(core_en), .o_vtune_clamp(clamp), .o_cal_busy(busy),
    .o_vco_subband(subband), .o_ref_div(ref_div), .o_n_int(n_int), .o_n_frac(n_frac),
    .o_modulator_cfg(mod_cfg), .o_exact_cfg(exact_cfg), .o_lock_detect_cfg(ld_cfg),
    .o_charge_pump_cfg(cp_cfg), .o_out_div_ratio(div_ratio), .o_gain_a(gain_a),
    .o_gain_b(gain_b), .o_out_mode(out_mode), .o_rf_mute(rf_mute)
  );
  host_serial_model u_host (
    .i_clock(clock), .i_readback(pin), .o_ser_enable(ser_enable), .o_ser_clk(ser_clk),
    .o_ser_data(ser_data)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // oscillator stand-in: period of 1, 2, 4 or 8 cycles by sub-band code
  always @(posedge clock) begin
    vco_cnt <= vco_cnt + 8'h01;
    vco_pulse <= (vco_cnt & ((8'h01 << subband[1:0]) - 8'h01)) == 8'h00;
  end

  function automatic reg_word_t cfg_out(input logic [5:0] addr);
    case (addr)
      `ADDR_REF_DIV: return ref_div;
      `ADDR_MOD_CFG: return mod_cfg;
      `ADDR_LD_CFG: return ld_cfg;
      `ADDR_CP_CFG: return cp_cfg;
      default: return exact_cfg;
    endcase
  endfunction : cfg_out
  task automatic check(input reg_word_t got, input reg_word_t exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] addr, input reg_word_t data);
    reg_word_t unused;
    u_host.frame(1'b0, addr, data, unused);
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [5:0] addr, output reg_word_t data);
    u_host.frame(1'b1, addr, 24'h000000, data);
  endtask : rd
  // bounded wait for the busy flag to reach a level
  task automatic wait_busy(input logic want, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (busy !== want && n < lim);
    if (busy !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, want);
      test_done();
    end
  endtask : wait_busy
  task automatic end_test(input string name);
    $display("test %s done, mismatches %0d", name, mismatches);
  endtask : end_test
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    sys_rst = 1'b1;
    chip_en = 1'b1;
    lock = 1'b1;
    vco_pulse = 1'b0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check(24'({rf_mute, pin, busy, div_ratio, subband}), 24'h010000);
    check(ref_div | n_int | n_frac | cp_cfg | mod_cfg, 24'h000000);
    end_test("reset");
    // configuration registers reach outputs and read back
    wr(`ADDR_LD_PIN_SEL, 24'h000003);
    for (int k = 0; k < 5; k++) begin
      wr(cfg_addr[k], cfg_val[k]);
      check(cfg_out(cfg_addr[k]), cfg_val[k]);
    end
    for (int k = 0; k < 5; k++) begin
      rd(cfg_addr[k], rd_val);
      check(rd_val, cfg_val[k]);
    end
    rd(6'h3F, rd_val);
    check(rd_val, 24'h000000);
    end_test("registers");
    // output divider codes, gains, mode and mute sources
    for (int k = 0; k < 5; k++) begin
      wr(`ADDR_OUT_DIV_GAIN, 24'h000240 | 24'(div_in[k]));
      check(24'(div_ratio), 24'(div_exp[k]));
      check(24'(rf_mute), 24'(div_in[k] == 6'h00));
    end
    check(24'({gain_b, gain_a}), 24'h000009);
    wr(`ADDR_OUT_STAGE, 24'h000280);
    check(24'({out_mode, rf_mute}), 24'h000004);
    @(posedge clock);
    lock <= 1'b0;
    repeat (3) @(negedge clock);
    check(24'(rf_mute), 24'h000001);
    @(posedge clock);
    lock <= 1'b1;
    chip_en <= 1'b0;
    repeat (3) @(negedge clock);
    check(24'({core_en, rf_mute}), 24'h000001);
    @(posedge clock);
    chip_en <= 1'b1;
    end_test("output stage");
    // calibration off: dividers and sub-band apply at once
    wr(`ADDR_CAL_CFG, 24'h000800);
    wr(`ADDR_FB_INT, 24'h000037);
    wr(`ADDR_FB_FRAC, 24'h123456);
    wr(`ADDR_MAN_SUBBAND, 24'h00005A);
    check(n_int, 24'h000037);
    check(n_frac, 24'h123456);
    check(24'({busy, subband}), 24'h00002D);
    end_test("manual");
    // calibration on: fraction write runs one calibration
    wr(`ADDR_CAL_CFG, 24'h000003);
    wr(`ADDR_FB_FRAC, 24'h2468AC);
    check(24'({busy, clamp}), 24'h000003);
    check(n_frac, 24'h123456);
    wait_busy(1'b0, 3000);
    check(n_frac, 24'h2468AC);
    chosen = subband;
    rd(`ADDR_MAN_SUBBAND, rd_val);
    check(rd_val, 24'({chosen, 1'b0}));
    wr(`ADDR_FB_FRAC, 24'h2468AC);
    check(24'(busy), 24'h000001);
    wait_busy(1'b0, 3000);
    check({n_frac[15:0], subband}, {16'h68AC, chosen});
    end_test("calibration");
    // loss of lock: exactly one rerun
    wr(`ADDR_CAL_CFG, 24'h020003);
    @(posedge clock);
    lock <= 1'b0;
    wait_busy(1'b1, 50);
    wait_busy(1'b0, 3000);
    @(posedge clock);
    lock <= 1'b1;
    repeat (4) @(posedge clock);
    lock <= 1'b0;
    seen = 1'b0;
    repeat (300) begin
      @(negedge clock);
      seen = seen | busy;
    end
    check(24'(seen), 24'h000000);
    end_test("relock");
    // lock pin shows lock outside read frames, readback inside them
    @(posedge clock);
    lock <= 1'b1;
    wr(`ADDR_LD_PIN_SEL, 24'h000002);
    check(24'(pin), 24'h000001);
    rd(`ADDR_LD_PIN_SEL, rd_val);
    check(rd_val, 24'h000002);
    end_test("lock pin");
    test_done();
  end
endmodule : synth_vco_subband_self_calibration_control_bench

bind synth_vco_subband_self_calibration_control synth_ctl_asserts u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_chip_enable_pin(i_chip_enable_pin),
  .i_ser_enable(i_ser_enable), .i_lock_indicator(i_lock_indicator),
  .o_core_enable(o_core_enable), .o_vtune_clamp(o_vtune_clamp), .o_cal_busy(o_cal_busy),
  .o_ref_div(o_ref_div), .o_n_int(o_n_int), .o_n_frac(o_n_frac),
  .o_modulator_cfg(o_modulator_cfg), .o_exact_cfg(o_exact_cfg),
  .o_lock_detect_cfg(o_lock_detect_cfg), .o_charge_pump_cfg(o_charge_pump_cfg),
  .o_out_div_ratio(o_out_div_ratio), .o_gain_a(o_gain_a), .o_gain_b(o_gain_b),
  .o_out_mode(o_out_mode), .o_rf_mute(o_rf_mute)
);
